/* hw/clkgen_map.svh */
// register map, field positions, reset values and counts of the clock block
// assumes a 32-bit apb register bus with byte addresses on paddr
`ifndef CLKGEN_MAP_SVH
`define CLKGEN_MAP_SVH

// register byte offsets
`define OSC_CTRL_OFS    8'h00
`define UNLOCK_KEY_OFS  8'h04
`define CONFIG_OFS      8'h08
`define STATUS_OFS      8'h0C

// unlock keys
`define KEY_FIRST       32'hAA996655
`define KEY_SECOND      32'h556699AA

// oscillator_control fields
`define OC_SWITCH       0
`define OC_XTAL_EN      1
`define OC_WAKE_EN      2
`define OC_USB_PLL_LOCKED        6
`define OC_NEXT_LSB     8
`define OC_CUR_LSB      12
`define OC_BUS_CLOCK_DIVIDER_LSB    19
`define OC_XREADY       22
`define OC_FAST_RC_DIVIDER_LSB   24

// configuration word fields
`define CF_FNOSC_LSB    0
`define CF_WDT_EN       3
`define CF_USB_PLL_IDIV_LSB 4
`define CF_USB_PLL_EN      7
`define CF_PLL_IDIV_LSB 8
`define CF_CKSM_LSB     14

// reset values
`define CONFIG_RST      32'h0000C007
`define NEXT_SRC_RST    3'h7
`define FAST_RC_DIVIDER_RST      3'h0
`define BUS_CLOCK_DIVIDER_RST       2'h0

// clock source codes
`define SRC_FRC         3'h0
`define SRC_FRC_PLL     3'h1
`define SRC_PRIMARY_CRYSTAL_OSC        3'h2
`define SRC_PRIMARY_CRYSTAL_OSC_PLL    3'h3
`define SRC_SLOW_INTERNAL_RC        3'h4
`define SRC_FRC_DIV     3'h7

// pll input divider code meaning divide by 2
`define PLL_IDIV_BY2    3'h1
// fail-safe monitor and two-speed codes of the switch/monitor field
`define CKSM_FAIL_SAFE_MONITOR_ON    2'h0
`define CKSM_ALL_OFF    2'h3

// timing counts
`define WARMUP_COUNT    11'h400
`define POWER_UP_TIMER_COUNT      32'h00000040
`define USB_PLL_LOCKED_COUNT     32'h00000080

`endif

/* hw/clkgen_pkg.sv */
// types shared by the clock generation block
// assumes clkgen_map.svh carries the numeric constants
package clkgen_pkg;

  typedef enum logic [1:0] {SRC_BOOT, SRC_WAIT_PRIMARY_CRYSTAL_OSC, SRC_RUN} src_state_t;

  typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN} key_state_t;

  typedef enum logic [1:0] {USB_CLK_PRIMARY, USB_CLK_USB_PLL_DIV2,
                            USB_CLK_WAKE_RC} usb_clk_src_t;

endpackage : clkgen_pkg

/* hw/clk_div_if.sv */
// carrier between the controller and a power-of-two tick divider
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface clk_div_if;
  logic [3:0] shift;
  logic       tick;
  modport ctrl (output shift, input tick);
  modport div  (input shift, output tick);
endinterface : clk_div_if

/* hw/tick_divider.sv */
// divide-by-2^shift tick generator, one pulse per period
// assumes shift is no larger than 8 and changes only from clocked logic
`timescale 1ns/1ps
module tick_divider #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic  pclk,
  input wire logic  presetn,
  // divider control
  clk_div_if.div    dv
);
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] last;

  assign last = CNT_W'((9'h001 << dv.shift) - 9'h001);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg <= '0;
      dv.tick   <= 1'b0;
    end
    else
    begin
      // a shrinking ratio must not strand the count above the new limit
      if (count_reg >= last)
      begin
        count_reg <= '0;
        dv.tick   <= 1'b1;
      end
      else
      begin
        count_reg <= count_reg + 1'b1;
        dv.tick   <= 1'b0;
      end
    end
  end
endmodule : tick_divider

/* hw/oscillator_clock_generation.sv */
// oscillator control, source selection and clock dividers
// assumes pclk is the core system clock and pins are asynchronous to it
`timescale 1ns/1ps
`include "clkgen_map.svh"
module oscillator_clock_generation #(
  parameter int POWER_UP_TIMER_CYCLES  = `POWER_UP_TIMER_COUNT,
  parameter int USB_PLL_LOCKED_CYCLES = `USB_PLL_LOCKED_COUNT
) (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // asynchronous oscillator and system pins
  input  wire logic                 xtal_clk_in,
  input  wire logic                 primary_crystal_osc_stable_in,
  input  wire logic                 regulator_en_in,
  input  wire logic                 usb_suspend_in,
  input  wire logic                 sleep_exit_in,
  // core side
  input  wire logic                 pb_access,
  output logic                      cpu_stall,
  // clock steering
  output logic      [2:0]           sys_clk_src,
  output logic      [2:0]           pll_input_div,
  output logic                      fast_rc_tick,
  output logic                      pb_clk_en,
  output logic                      xtal_osc_run,
  output logic                      slow_rc_run,
  output clkgen_pkg::usb_clk_src_t  usb_clk_sel,
  output logic                      usb_pll_run,
  output logic      [2:0]           usb_pll_input_div
);
  import clkgen_pkg::*;

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic logic [3:0] frc_shift(input logic [2:0] code);
    frc_shift = (code == 3'h7) ? 4'h8 : {1'b0, code};
  endfunction : frc_shift

  function automatic logic uses_pll(input logic [2:0] src);
    uses_pll = (src == `SRC_FRC_PLL) || (src == `SRC_PRIMARY_CRYSTAL_OSC_PLL);
  endfunction : uses_pll

  function automatic logic is_primary(input logic [2:0] src);
    is_primary = (src == `SRC_PRIMARY_CRYSTAL_OSC) || (src == `SRC_PRIMARY_CRYSTAL_OSC_PLL);
  endfunction : is_primary

  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  logic [4:0]        sync1_reg;
  logic [4:0]        sync2_reg;
  logic              xtal_d3_reg;
  logic              sleep_d3_reg;
  logic              xtal_edge;
  logic              sleep_exit;
  logic              primary_crystal_osc_ready;
  logic              regulator_en;
  logic              usb_suspend;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // strap reads as regulator on until synced, so the slow rc stays off
      sync1_reg    <= 5'h04;
      sync2_reg    <= 5'h04;
      xtal_d3_reg  <= 1'b0;
      sleep_d3_reg <= 1'b0;
    end
    else
    begin
      sync1_reg    <= {sleep_exit_in, usb_suspend_in, regulator_en_in,
                       primary_crystal_osc_stable_in, xtal_clk_in};
      sync2_reg    <= sync1_reg;
      xtal_d3_reg  <= sync2_reg[0];
      sleep_d3_reg <= sync2_reg[4];
    end
  end

  assign xtal_edge    = sync2_reg[0] & ~xtal_d3_reg;
  assign primary_crystal_osc_ready   = sync2_reg[1];
  assign regulator_en = sync2_reg[2];
  assign usb_suspend  = sync2_reg[3];
  assign sleep_exit   = sync2_reg[4] & ~sleep_d3_reg;

  // -------------------------------------------------------------------
  // registers and apb decode
  // -------------------------------------------------------------------
  logic              setup;
  logic              wr_done;
  logic              ctrl_wr;
  logic              key_wr;
  logic              cfg_wr;
  logic              mapped;
  logic [31:0]       rd_mux;
  key_state_t        key_reg;
  logic              switch_reg;
  logic              xtal_en_reg;
  logic              wake_en_reg;
  logic [2:0]        next_src_reg;
  logic [1:0]        bus_clock_divider_reg;
  logic [2:0]        fast_rc_divider_reg;
  logic [31:0]       config_reg;
  logic [2:0]        cur_src_reg;
  logic              xready_reg;
  logic              usb_pll_locked_reg;
  logic              power_up_timer_done_reg;
  logic [1:0]        cksm;
  logic              two_speed_en;
  logic              switch_en;

  assign setup   = psel & ~penable;
  assign wr_done = psel & penable & pready & pwrite;
  assign mapped  = (paddr == `OSC_CTRL_OFS) || (paddr == `UNLOCK_KEY_OFS) ||
                   (paddr == `CONFIG_OFS) || (paddr == `STATUS_OFS);
  assign ctrl_wr = wr_done && paddr == `OSC_CTRL_OFS
                   && key_reg == KEY_OPEN;
  assign key_wr  = wr_done && paddr == `UNLOCK_KEY_OFS;
  assign cfg_wr  = wr_done && paddr == `CONFIG_OFS;

  assign cksm         = config_reg[`CF_CKSM_LSB +: 2];
  assign switch_en    = ~cksm[1];
  assign two_speed_en = (cksm != `CKSM_ALL_OFF);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `OSC_CTRL_OFS:
      begin
        rd_mux[`OC_SWITCH]         = switch_reg;
        rd_mux[`OC_XTAL_EN]        = xtal_en_reg;
        rd_mux[`OC_WAKE_EN]        = wake_en_reg;
        rd_mux[`OC_USB_PLL_LOCKED]          = usb_pll_locked_reg;
        rd_mux[`OC_NEXT_LSB +: 3]  = next_src_reg;
        rd_mux[`OC_CUR_LSB +: 3]   = cur_src_reg;
        rd_mux[`OC_BUS_CLOCK_DIVIDER_LSB +: 2] = bus_clock_divider_reg;
        rd_mux[`OC_XREADY]         = xready_reg;
        rd_mux[`OC_FAST_RC_DIVIDER_LSB +: 3] = fast_rc_divider_reg;
      end
      `CONFIG_OFS:
        rd_mux = config_reg;
      `STATUS_OFS:
        rd_mux = {28'h0000000, key_reg == KEY_OPEN, primary_crystal_osc_ready,
                  power_up_timer_done_reg, slow_rc_run};
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  // zero wait states: pready rises for the access phase of every transfer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite)
        prdata <= rd_mux;
    end
  end

  // -------------------------------------------------------------------
  // unlock sequence
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      key_reg <= KEY_LOCKED;
    else if (key_wr)
    begin
      if (key_reg == KEY_LOCKED && pwdata == `KEY_FIRST)
        key_reg <= KEY_HALF;
      else if (key_reg == KEY_HALF && pwdata == `KEY_SECOND)
        key_reg <= KEY_OPEN;
      else
        key_reg <= KEY_LOCKED;
    end
  end

  // -------------------------------------------------------------------
  // software control fields
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xtal_en_reg  <= 1'b0;
      wake_en_reg  <= 1'b0;
      next_src_reg <= `NEXT_SRC_RST;
      bus_clock_divider_reg    <= `BUS_CLOCK_DIVIDER_RST;
      fast_rc_divider_reg   <= `FAST_RC_DIVIDER_RST;
    end
    else if (ctrl_wr)
    begin
      xtal_en_reg  <= pwdata[`OC_XTAL_EN];
      wake_en_reg  <= pwdata[`OC_WAKE_EN];
      next_src_reg <= pwdata[`OC_NEXT_LSB +: 3];
      bus_clock_divider_reg    <= pwdata[`OC_BUS_CLOCK_DIVIDER_LSB +: 2];
      fast_rc_divider_reg   <= pwdata[`OC_FAST_RC_DIVIDER_LSB +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      config_reg <= `CONFIG_RST;
    else if (cfg_wr)
      config_reg <= pwdata;
  end

  // -------------------------------------------------------------------
  // current source: two-speed start and software switch
  // -------------------------------------------------------------------
  src_state_t        src_state_reg;
  logic [2:0]        boot_src;

  assign boot_src = config_reg[`CF_FNOSC_LSB +: 3];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_state_reg <= SRC_BOOT;
      cur_src_reg   <= `SRC_FRC;
      switch_reg    <= 1'b0;
    end
    else if (sleep_exit)
    begin
      src_state_reg <= SRC_BOOT;
      switch_reg    <= 1'b0;
    end
    else
    begin
      case (src_state_reg)
        SRC_BOOT:
        begin
          // fast rc carries the core while the crystal settles
          if (two_speed_en && is_primary(boot_src) && !primary_crystal_osc_ready)
          begin
            cur_src_reg   <= `SRC_FRC;
            src_state_reg <= SRC_WAIT_PRIMARY_CRYSTAL_OSC;
          end
          else
          begin
            cur_src_reg   <= boot_src;
            src_state_reg <= SRC_RUN;
          end
        end
        SRC_WAIT_PRIMARY_CRYSTAL_OSC:
          if (primary_crystal_osc_ready)
          begin
            cur_src_reg   <= boot_src;
            src_state_reg <= SRC_RUN;
          end
        SRC_RUN:
          // switch waits for a stable crystal when one is the target
          if (ctrl_wr && pwdata[`OC_SWITCH] && switch_en)
            switch_reg <= 1'b1;
          else if (switch_reg &&
                   (!is_primary(next_src_reg) || primary_crystal_osc_ready))
          begin
            cur_src_reg <= next_src_reg;
            switch_reg  <= 1'b0;
          end
        default:
          src_state_reg <= SRC_BOOT;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_clk_src   <= `SRC_FRC;
      pll_input_div <= `PLL_IDIV_BY2;
    end
    else
    begin
      sys_clk_src <= cur_src_reg;
      if (cur_src_reg == `SRC_FRC_PLL)
        pll_input_div <= `PLL_IDIV_BY2;
      else
        pll_input_div <= config_reg[`CF_PLL_IDIV_LSB +: 3];
    end
  end

  // -------------------------------------------------------------------
  // low-power crystal oscillator
  // -------------------------------------------------------------------
  logic [10:0]       warm_cnt_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      warm_cnt_reg <= 11'h000;
      xready_reg   <= 1'b0;
      xtal_osc_run <= 1'b0;
    end
    else
    begin
      xtal_osc_run <= xtal_en_reg;
      if (!xtal_en_reg)
      begin
        warm_cnt_reg <= 11'h000;
        xready_reg   <= 1'b0;
      end
      else if (warm_cnt_reg == `WARMUP_COUNT)
        xready_reg <= 1'b1;
      else if (xtal_edge)
        warm_cnt_reg <= warm_cnt_reg + 11'h001;
    end
  end

  // -------------------------------------------------------------------
  // slow rc and power-up timer
  // -------------------------------------------------------------------
  logic [31:0]       power_up_timer_cnt_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_up_timer_cnt_reg  <= 32'h0000_0000;
      power_up_timer_done_reg <= 1'b0;
      slow_rc_run   <= 1'b0;
    end
    else if (!power_up_timer_done_reg)
    begin
      slow_rc_run <= ~regulator_en;
      if (power_up_timer_cnt_reg == 32'(POWER_UP_TIMER_CYCLES - 1))
        power_up_timer_done_reg <= 1'b1;
      else
        power_up_timer_cnt_reg <= power_up_timer_cnt_reg + 32'h0000_0001;
    end
    else
      slow_rc_run <= (cksm == `CKSM_FAIL_SAFE_MONITOR_ON)
                     | config_reg[`CF_WDT_EN]
                     | (cur_src_reg == `SRC_SLOW_INTERNAL_RC);
  end

  // -------------------------------------------------------------------
  // dividers: fast rc postscaler and peripheral bus clock
  // -------------------------------------------------------------------
  clk_div_if frc_if ();
  clk_div_if pb_if ();

  assign frc_if.shift = frc_shift(fast_rc_divider_reg);
  assign pb_if.shift  = {2'b00, bus_clock_divider_reg};

  tick_divider #(.CNT_W(8)) u_frc_div (
    .pclk    (pclk),
    .presetn (presetn),
    .dv      (frc_if)
  );

  tick_divider #(.CNT_W(8)) u_pb_div (
    .pclk    (pclk),
    .presetn (presetn),
    .dv      (pb_if)
  );

  // of the core-side logic only the bus stall below looks at the bus divider
  assign fast_rc_tick = frc_if.tick;
  assign pb_clk_en    = pb_if.tick;

  // -------------------------------------------------------------------
  // back-to-back bus stall
  // -------------------------------------------------------------------
  logic              pb_busy_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pb_busy_reg <= 1'b0;
      cpu_stall   <= 1'b0;
    end
    else
    begin
      // the pending access completes on the next bus clock enable
      if (pb_access && bus_clock_divider_reg != 2'h0)
        pb_busy_reg <= 1'b1;
      else if (pb_if.tick)
        pb_busy_reg <= 1'b0;
      cpu_stall <= pb_busy_reg & pb_access & ~pb_if.tick;
    end
  end

  // -------------------------------------------------------------------
  // usb clock and usb pll lock
  // -------------------------------------------------------------------
  logic [31:0]       usb_pll_locked_cnt_reg;
  logic              usb_pll_en;

  assign usb_pll_en = config_reg[`CF_USB_PLL_EN];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      usb_pll_locked_cnt_reg <= 32'h0000_0000;
      usb_pll_locked_reg     <= 1'b0;
    end
    else if (!usb_pll_en || !uses_pll(cur_src_reg))
    begin
      usb_pll_locked_cnt_reg <= 32'h0000_0000;
      usb_pll_locked_reg     <= 1'b0;
    end
    else if (usb_pll_locked_cnt_reg == 32'(USB_PLL_LOCKED_CYCLES - 1))
      usb_pll_locked_reg <= 1'b1;
    else
      usb_pll_locked_cnt_reg <= usb_pll_locked_cnt_reg + 32'h0000_0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      usb_clk_sel       <= USB_CLK_PRIMARY;
      usb_pll_run       <= 1'b0;
      usb_pll_input_div <= 3'h0;
    end
    else
    begin
      usb_pll_run       <= usb_pll_en;
      usb_pll_input_div <= config_reg[`CF_USB_PLL_IDIV_LSB +: 3];
      if (usb_suspend && wake_en_reg)
        usb_clk_sel <= USB_CLK_WAKE_RC;
      else if (usb_pll_en)
        usb_clk_sel <= USB_CLK_USB_PLL_DIV2;
      else
        usb_clk_sel <= USB_CLK_PRIMARY;
    end
  end

endmodule : oscillator_clock_generation

/* verification/clkgen_sva.sv */
// checker of the clock block ports
// assumes it is bound into oscillator_clock_generation
`timescale 1ns/1ps
module clkgen_sva
  import clkgen_pkg::*;
(
  // clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // apb
  input wire logic [7:0]          paddr,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pready,
  input wire logic                pslverr,
  // core side and clock steering
  input wire logic                pb_access,
  input wire logic                usb_suspend_in,
  input wire logic                cpu_stall,
  input wire logic                pb_clk_en,
  input wire logic                fast_rc_tick,
  input wire logic [2:0]          sys_clk_src,
  input wire logic [2:0]          pll_input_div,
  input wire clkgen_pkg::usb_clk_src_t usb_clk_sel
);
  // --------------------
  // port relations
  // --------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  setup_pready_a: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  unmapped_err_a: assert property
    (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h0C))
    else $error("pslverr does not follow address");
  pll_div_forced_a: assert property
    ((sys_clk_src == 3'h1) [*2] |-> pll_input_div == 3'h1)
    else $error("pll divider not forced");
  stall_cause_a: assert property
    (cpu_stall |-> $past(pb_access) && !$past(pb_clk_en))
    else $error("stall without pending access");
  pb_gap_a: assert property
    ($fell(pb_clk_en) |-> ##[1:8] pb_clk_en)
    else $error("bus enable gap above 8");
  frc_tick_gap_a: assert property
    ($fell(fast_rc_tick) |-> ##[1:256] fast_rc_tick)
    else $error("fast rc tick gap above 256");
  wake_rc_cause_a: assert property
    (usb_clk_sel == USB_CLK_WAKE_RC |-> $past(usb_suspend_in, 3))
    else $error("wake rc used outside suspend");
endmodule : clkgen_sva

bind oscillator_clock_generation clkgen_sva u_sva (
  .pclk, .presetn, .paddr, .psel, .penable, .pready, .pslverr,
  .pb_access, .usb_suspend_in, .cpu_stall, .pb_clk_en, .fast_rc_tick,
  .sys_clk_src, .pll_input_div, .usb_clk_sel
);

/* verification/test_oscillator_clock_generation.sv */
// self-checking bench of the clock generation block
// assumes clkgen_map.svh on the include path and the checker bound in
`timescale 1ns/1ps
`include "clkgen_map.svh"
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("wrong value at %0t: %h not %h", $time, g, e); \
    end \
  end
module test_oscillator_clock_generation;
  import clkgen_pkg::*;
  // --------------------
  // design and inputs
  // --------------------
  localparam int ULK = 8;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [31:0]  pwdata = 32'h0;
  logic         xtal_clk_in = 1'b0;
  logic         primary_crystal_osc_stable_in = 1'b0;
  logic         usb_suspend_in = 1'b0;
  logic         sleep_exit_in = 1'b0;
  logic         regulator_en_in = 1'b1;
  logic         pb_access = 1'b0;
  logic [31:0]  prdata, rdata;
  logic         pready, pslverr, err, cpu_stall, fast_rc_tick, pb_clk_en;
  logic         xtal_osc_run, slow_rc_run, usb_pll_run;
  logic [2:0]   sys_clk_src, pll_input_div, usb_pll_input_div;
  usb_clk_src_t usb_clk_sel;
  int           n_errors = 0;
  int           checks_done = 0;
  int           p, n;

  // regulator strap on for the main run, off for the second power-up
  oscillator_clock_generation #(.POWER_UP_TIMER_CYCLES(4), .USB_PLL_LOCKED_CYCLES(ULK)) DUT (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .xtal_clk_in, .primary_crystal_osc_stable_in,
    .regulator_en_in, .usb_suspend_in, .sleep_exit_in, .pb_access,
    .cpu_stall, .sys_clk_src, .pll_input_div, .fast_rc_tick, .pb_clk_en,
    .xtal_osc_run, .slow_rc_run, .usb_clk_sel, .usb_pll_run,
    .usb_pll_input_div
  );

  always #4 pclk = ~pclk;

  // --------------------
  // access tasks
  // --------------------
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    psel   <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    rdata = prdata;
    err = pslverr;
    `CHK(pready, 1'b1)
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    `CHK(rdata & m, e)
  endtask : rd

  // control word: b[0] switch, b[1] crystal, b[2] usb wake rc
  task automatic woc(input logic [2:0] nx, input logic [2:0] fd,
                     input logic [1:0] pd, input logic [2:0] b);
    apb(`OSC_CTRL_OFS, 1'b1, (32'(fd) << `OC_FAST_RC_DIVIDER_LSB)
        | (32'(pd) << `OC_BUS_CLOCK_DIVIDER_LSB) | (32'(nx) << `OC_NEXT_LSB) | 32'(b));
  endtask : woc

  task automatic key(input logic [31:0] d);
    apb(`UNLOCK_KEY_OFS, 1'b1, d);
  endtask : key

  // crystal edges held two cycles each so the synchroniser sees them
  task automatic xtal(input int e);
    repeat (e)
    begin
      repeat (2) @(posedge pclk);
      xtal_clk_in <= 1'b1;
      repeat (2) @(posedge pclk);
      xtal_clk_in <= 1'b0;
    end
    repeat (6) @(posedge pclk);
  endtask : xtal

  // only the first gap may be cut short by a divider change
  task automatic period(input logic pb, output int q);
    int k;
    repeat (3)
    begin
      k = 0;
      do
      begin
        @(posedge pclk);
        k++;
      end
      while ((pb ? pb_clk_en : fast_rc_tick) !== 1'b1 && k < 600);
      q = k;
    end
  endtask : period

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // --------------------
  // tests
  // --------------------
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(slow_rc_run, 1'b0)
    rd(`CONFIG_OFS, '1, `CONFIG_RST);
    rd(`OSC_CTRL_OFS, '1, 32'h00007700);
    `CHK(sys_clk_src, `SRC_FRC_DIV)
    rd(8'h10, '1, 32'h0);
    `CHK(err, 1'b1)
    woc(3'h7, 3'h0, 2'h0, 3'h2);
    rd(`OSC_CTRL_OFS, 32'h2, 32'h0);
    key(`KEY_FIRST);
    key(`KEY_SECOND);
    woc(3'h7, 3'h0, 2'h0, 3'h2);
    rd(`OSC_CTRL_OFS, 32'h2, 32'h2);
    `CHK(xtal_osc_run, 1'b1)
    key(`KEY_SECOND);
    key(`KEY_FIRST);
    woc(3'h7, 3'h0, 2'h0, 3'h0);
    rd(`OSC_CTRL_OFS, 32'h2, 32'h2);
    key(`KEY_SECOND);
    xtal(1023);
    rd(`OSC_CTRL_OFS, 32'h00400000, 32'h0);
    xtal(1);
    rd(`OSC_CTRL_OFS, 32'h00400000, 32'h00400000);
    for (int c = 0; c < 8; c++)
    begin
      woc(3'h7, c[2:0], 2'h0, 3'h2);
      period(1'b0, p);
      `CHK(p, (c == 7) ? 256 : (1 << c))
    end
    for (int c = 0; c < 4; c++)
    begin
      woc(3'h7, 3'h0, c[1:0], 3'h2);
      period(1'b1, p);
      `CHK(p, 1 << c)
      period(1'b0, p);
      `CHK(p, 1)
      n = 0;
      pb_access <= 1'b1;
      repeat (8)
      begin
        @(posedge pclk);
        n += int'(cpu_stall === 1'b1);
      end
      pb_access <= 1'b0;
      `CHK(n != 0, c != 0)
    end
    apb(`CONFIG_OFS, 1'b1, 32'h000040B7);
    repeat (3) @(posedge pclk);
    `CHK(usb_pll_run, 1'b1)
    `CHK(usb_pll_input_div, 3'h3)
    woc(`SRC_FRC_PLL, 3'h0, 2'h0, 3'h3);
    repeat (4) @(posedge pclk);
    `CHK(sys_clk_src, `SRC_FRC_PLL)
    `CHK(pll_input_div, `PLL_IDIV_BY2)
    `CHK(xtal_osc_run, 1'b1)
    repeat (ULK + 4) @(posedge pclk);
    rd(`OSC_CTRL_OFS, 32'h7040, 32'h1040);
    woc(`SRC_SLOW_INTERNAL_RC, 3'h0, 2'h0, 3'h1);
    repeat (4) @(posedge pclk);
    rd(`OSC_CTRL_OFS, 32'h00407042, 32'h4000);
    `CHK(slow_rc_run, 1'b1)
    `CHK(xtal_osc_run, 1'b0)
    woc(`SRC_FRC_DIV, 3'h0, 2'h0, 3'h5);
    repeat (4) @(posedge pclk);
    `CHK(slow_rc_run, 1'b0)
    usb_suspend_in <= 1'b1;
    repeat (5) @(posedge pclk);
    `CHK(usb_clk_sel, USB_CLK_WAKE_RC)
    usb_suspend_in <= 1'b0;
    repeat (5) @(posedge pclk);
    `CHK(usb_clk_sel, USB_CLK_USB_PLL_DIV2)
    apb(`CONFIG_OFS, 1'b1, 32'h00000002);
    // pin sync, edge detect, boot state, then the output flop
    sleep_exit_in <= 1'b1;
    repeat (7) @(posedge pclk);
    `CHK(sys_clk_src, `SRC_FRC)
    primary_crystal_osc_stable_in <= 1'b1;
    repeat (5) @(posedge pclk);
    `CHK(sys_clk_src, `SRC_PRIMARY_CRYSTAL_OSC)
    sleep_exit_in <= 1'b0;
    primary_crystal_osc_stable_in <= 1'b0;
    apb(`CONFIG_OFS, 1'b1, 32'h0000C002);
    sleep_exit_in <= 1'b1;
    repeat (7) @(posedge pclk);
    `CHK(sys_clk_src, `SRC_PRIMARY_CRYSTAL_OSC)
    // second power-up without regulator: slow rc runs for the timer
    regulator_en_in <= 1'b0;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK(slow_rc_run, 1'b1)
    end_of_test();
  end

  // hang guard, about seven times the expected run
  initial
  begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    end_of_test();
  end
endmodule : test_oscillator_clock_generation
